//--- core/pmas_top.sv
`timescale 1ns/1ps
module pmas_top
    import pmas_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         reset_n_i,
    input  wire logic         mdc_i,
    input  wire logic         mdio_i,
    output logic              mdio_o,
    output logic              mdio_oe_o,
    input  wire logic [1:0]   port_address_base_pins_i,
    input  wire pmas_an_evt_s an_evt_i [NUM_PORTS],
    output logic [1:0]        port_address_base_o,
    output logic              frame_busy_o
);

    // pin synchronisers
    logic        mdc_meta;
    logic        mdc_sync;
    logic        mdc_prev;
    logic        mdio_meta;
    logic        mdio_sync;
    logic [1:0]  base_meta;
    logic [1:0]  base_sync;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            mdc_meta  <= 1'b0;
            mdc_sync  <= 1'b0;
            mdc_prev  <= 1'b0;
            mdio_meta <= 1'b1;
            mdio_sync <= 1'b1;
        end else begin
            mdc_meta  <= mdc_i;
            mdc_sync  <= mdc_meta;
            mdc_prev  <= mdc_sync;
            mdio_meta <= mdio_i;
            mdio_sync <= mdio_meta;
        end
    end

    // base pins flow through during reset, ready for capture at release
    always_ff @(posedge clk_sys_i) begin
        base_meta <= port_address_base_pins_i;
        base_sync <= base_meta;
    end

    logic mdc_rise;
    assign mdc_rise = mdc_sync & ~mdc_prev;

    // address base capture at reset release
    logic [1:0] addr_base;
    logic       base_held;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            addr_base <= 2'h0;
            base_held <= 1'b0;
        end else if (!base_held) begin
            addr_base <= base_sync;
            base_held <= 1'b1;
        end
    end

    assign port_address_base_o = addr_base;

    // per-port status registers
    pmas_port_regs_s port_regs [NUM_PORTS];
    logic [NUM_PORTS-1:0] exp_read;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        pmas_port_status u_status (
            .clk_sys_i  (clk_sys_i),
            .reset_n_i  (reset_n_i),
            .evt_i      (an_evt_i[p]),
            .exp_read_i (exp_read[p]),
            .regs_o     (port_regs[p])
        );
    end

    // register read selection
    function automatic logic [15:0] read_mux(
        input pmas_port_regs_s regs,
        input logic [4:0]      reg_addr
    );
        logic [15:0] v;
        v = READ_UNMAPPED;
        if (reg_addr == REG_PARTNER_ABILITY) begin
            v = regs.partner_ability;
        end else if (reg_addr == REG_AUTONEG_EXPANSION) begin
            v = regs.autoneg_expansion;
        end
        return v;
    endfunction

    // frame decoder
    pmas_state_e state;
    logic [5:0]  ones_cnt;
    logic        pre_done;
    logic [4:0]  bit_cnt;
    logic [1:0]  opcode;
    logic [9:0]  addr_shift;
    logic [15:0] data_shift;
    logic        read_hit;
    logic [2:0]  hit_port;
    logic [9:0]  next_addr;

    assign next_addr = {addr_shift[8:0], mdio_sync};

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state      <= ST_IDLE;
            ones_cnt   <= 6'h00;
            pre_done   <= 1'b0;
            bit_cnt    <= 5'h00;
            opcode     <= 2'h0;
            addr_shift <= 10'h000;
            read_hit   <= 1'b0;
            hit_port   <= 3'h0;
        end else if (mdc_rise) begin
            case (state)
                ST_IDLE: begin
                    if (mdio_sync) begin
                        if (ones_cnt != PREAMBLE_FULL) begin
                            ones_cnt <= ones_cnt + 6'h01;
                        end
                    end else if (ones_cnt == PREAMBLE_FULL) begin
                        state    <= ST_START;
                        pre_done <= 1'b1;
                    end else if (pre_done && ones_cnt != 6'h00) begin
                        state <= ST_START;
                    end else begin
                        ones_cnt <= 6'h00;
                    end
                end
                ST_START: begin
                    ones_cnt <= 6'h00;
                    bit_cnt  <= 5'h00;
                    if (mdio_sync) begin
                        state <= ST_OPCODE;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_OPCODE: begin
                    opcode  <= {opcode[0], mdio_sync};
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'h01) begin
                        state   <= ST_ADDR;
                        bit_cnt <= 5'h00;
                    end
                end
                ST_ADDR: begin
                    addr_shift <= next_addr;
                    bit_cnt    <= bit_cnt + 5'h01;
                    if (bit_cnt == ADDR_BITS_M1) begin
                        state    <= ST_TURN;
                        hit_port <= next_addr[7:5];
                        read_hit <= (opcode == OP_READ) &&
                                    (next_addr[9:8] == addr_base);
                    end
                end
                ST_TURN: begin
                    bit_cnt <= 5'h00;
                    if (read_hit) begin
                        state <= ST_RDATA;
                    end else begin
                        state <= ST_SKIP;
                    end
                end
                ST_RDATA: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == SKIP_BITS_M1) begin
                        state    <= ST_IDLE;
                        read_hit <= 1'b0;
                    end
                end
                ST_SKIP: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == SKIP_BITS_M1) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // read data load and serial drive
    logic turn_read;
    assign turn_read = mdc_rise && (state == ST_TURN) && read_hit;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            data_shift <= 16'h0000;
            mdio_o     <= 1'b1;
            mdio_oe_o  <= 1'b0;
        end else if (turn_read) begin
            // snapshot before clear-on-read
            data_shift <= read_mux(port_regs[hit_port], addr_shift[4:0]);
            mdio_o     <= 1'b0;
            mdio_oe_o  <= 1'b1;
        end else if (mdc_rise && state == ST_RDATA) begin
            if (bit_cnt == SKIP_BITS_M1) begin
                mdio_oe_o <= 1'b0;
                mdio_o    <= 1'b1;
            end else begin
                mdio_o     <= data_shift[15];
                data_shift <= {data_shift[14:0], 1'b0};
            end
        end else if (mdc_rise && state == ST_TURN) begin
            mdio_oe_o <= 1'b0;
        end
    end

    // first data bit follows the turnaround zero
    logic first_bit;
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            first_bit <= 1'b0;
        end else if (turn_read) begin
            first_bit <= 1'b1;
        end else if (mdc_rise) begin
            first_bit <= 1'b0;
        end
    end

    // clear-on-read pulse to the addressed port
    always_comb begin
        exp_read = '0;
        if (turn_read && addr_shift[4:0] == REG_AUTONEG_EXPANSION) begin
            exp_read[hit_port] = 1'b1;
        end
    end

    assign frame_busy_o = (state != ST_IDLE) || first_bit;

endmodule

//--- core/pmas_pkg.sv
// Notes on behaviour
// - partner next-page request copied into partner ability bit 15, else ignored.
// - partner remote fault recorded in bit 13, no action taken.
// - bit 14 shows partner code word was received during negotiation.
// - four partner speed/duplex bits cleared on negotiation restart or reset.
// - partner 100Base-T4 bit mirrors partner advertisement.
// - partner pause bit mirrors partner advertised pause.
// - partner selector bits 4:0 held, cleared on restart or reset.
// - expansion bit 4 latches parallel-detect fault, cleared by read or reset.
// - expansion bit 3 always equals partner ability bit 15.
// - expansion bit 2 is always zero.
// - expansion bit 1 latches on new page, cleared on link loss or reset.
// - with negotiation enabled outside fiber mode, expansion bit 0 is one only once partner known negotiation capable.
// - fiber mode or negotiation disabled forces expansion bit 0 to one.
// - master clocks at most 25MHz; device samples data on rising clock edge.
// - read frame: ones, 01, 10, port, reg, Z0 turnaround, 16 bits driven.
// - after data both sides release line, which rests pulled high.
// - after one full 32-bit preamble since reset, preamble may be omitted if at least one idle bit separates frames.
// - port address upper two bits from base pins; ports use 000..111.
// - port acts only on matching address, else ignores and leaves line undriven.
// - base pins captured at reset release and held until next reset.
package pmas_pkg;

    localparam int          NUM_PORTS     = 8;
    localparam logic [5:0]  PREAMBLE_FULL = 6'h20;
    localparam logic [1:0]  OP_READ       = 2'h2;
    localparam logic [1:0]  OP_WRITE      = 2'h1;
    localparam logic [4:0]  ADDR_BITS_M1  = 5'h09;
    localparam logic [4:0]  DATA_BITS_M1  = 5'h0f;
    localparam logic [4:0]  SKIP_BITS_M1  = 5'h10;

    localparam logic [4:0]  REG_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0]  REG_AUTONEG_EXPANSION = 5'h06;

    localparam logic [15:0] PARTNER_ABILITY_RESET = 16'h0000;
    localparam logic [15:0] PARTNER_ABILITY_MASK  = 16'he7ff;
    localparam int          PA_NEXT_PAGE_BIT  = 15;
    localparam int          EXP_PD_FAULT_BIT  = 4;
    localparam int          EXP_PARTNER_NP_BIT = 3;
    localparam int          EXP_LOCAL_NP_BIT  = 2;
    localparam int          EXP_PAGE_RX_BIT   = 1;
    localparam int          EXP_PARTNER_AN_BIT = 0;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_OPCODE,
        ST_ADDR,
        ST_TURN,
        ST_RDATA,
        ST_SKIP
    } pmas_state_e;

    typedef struct packed {
        logic        an_enable;
        logic        fiber_100_mode;
        logic        partner_an_able;
        logic        an_restart;
        logic        word_valid;
        logic [15:0] word;
        logic        pd_fault;
        logic        page_rx;
        logic        link_lost;
    } pmas_an_evt_s;

    typedef struct packed {
        logic [15:0] partner_ability;
        logic [15:0] autoneg_expansion;
    } pmas_port_regs_s;

endpackage

//--- core/pmas_port_status.sv
`timescale 1ns/1ps
module pmas_port_status
    import pmas_pkg::*;
(
    input  wire logic            clk_sys_i,
    input  wire logic            reset_n_i,
    input  wire pmas_an_evt_s    evt_i,
    input  wire logic            exp_read_i,
    output pmas_port_regs_s      regs_o
);

    logic [15:0] partner_ability;
    logic        pd_fault;
    logic        page_rx;

    // partner word capture, cleared on restart
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            partner_ability <= PARTNER_ABILITY_RESET;
        end else if (evt_i.an_restart) begin
            partner_ability <= PARTNER_ABILITY_RESET;
        end else if (evt_i.word_valid) begin
            partner_ability <= evt_i.word & PARTNER_ABILITY_MASK;
        end
    end

    // parallel detect fault, set wins over read clear
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pd_fault <= 1'b0;
        end else if (evt_i.pd_fault) begin
            pd_fault <= 1'b1;
        end else if (exp_read_i) begin
            pd_fault <= 1'b0;
        end
    end

    // page received, set wins over link loss
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            page_rx <= 1'b0;
        end else if (evt_i.page_rx) begin
            page_rx <= 1'b1;
        end else if (evt_i.link_lost) begin
            page_rx <= 1'b0;
        end
    end

    always_comb begin
        regs_o.partner_ability                     = partner_ability;
        regs_o.autoneg_expansion                   = 16'h0000;
        regs_o.autoneg_expansion[EXP_PD_FAULT_BIT] = pd_fault;
        regs_o.autoneg_expansion[EXP_PARTNER_NP_BIT] =
            partner_ability[PA_NEXT_PAGE_BIT];
        regs_o.autoneg_expansion[EXP_LOCAL_NP_BIT] = 1'b0;
        regs_o.autoneg_expansion[EXP_PAGE_RX_BIT]  = page_rx;
        if (evt_i.fiber_100_mode || !evt_i.an_enable) begin
            regs_o.autoneg_expansion[EXP_PARTNER_AN_BIT] = 1'b1;
        end else begin
            regs_o.autoneg_expansion[EXP_PARTNER_AN_BIT] =
                evt_i.partner_an_able;
        end
    end

endmodule

//--- test/pmas_top_monitor.sv
`timescale 1ns/1ps
module pmas_top_monitor
    import pmas_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       reset_n_i,
    input wire logic       mdc_i,
    input wire logic       mdio_o,
    input wire logic       mdio_oe_o,
    input wire logic [1:0] port_address_base_pins_i,
    input wire logic [1:0] port_address_base_o,
    input wire logic       frame_busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    chk_reset_quiet: assert property (disable iff (1'b0)
        !reset_n_i |=> !mdio_oe_o && mdio_o && !frame_busy_o
            && port_address_base_o == 2'h0)
        else $error("outputs not quiet in reset");
    chk_release_high: assert property (!mdio_oe_o |-> mdio_o)
        else $error("undriven output not high");
    chk_turn_zero: assert property ($rose(mdio_oe_o) |-> !mdio_o)
        else $error("turnaround bit not zero");
    chk_drive_bit: assert property ($rose(mdio_oe_o) |-> mdio_oe_o[*8])
        else $error("drive shorter than one bit");
    chk_drive_len: assert property (
        $rose(mdio_oe_o) |-> ##[132:140] !mdio_oe_o)
        else $error("drive not released after data");
    chk_drive_busy: assert property (mdio_oe_o |-> frame_busy_o)
        else $error("drive outside a frame");
    chk_bit_on_mdc: assert property (
        mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |->
            $past(mdc_i) || $past(mdc_i, 2) || $past(mdc_i, 3))
        else $error("data changed without clock rise");
    chk_base_take: assert property (
        $rose(reset_n_i) && port_address_base_pins_i ==
            $past(port_address_base_pins_i, 4) |=>
            port_address_base_o == $past(port_address_base_pins_i, 2))
        else $error("base not captured");
    chk_base_hold: assert property (
        $past(reset_n_i) && $past(reset_n_i, 2) |->
            $stable(port_address_base_o))
        else $error("base changed after capture");
endmodule

//--- test/pmas_mgmt_master.sv
`timescale 1ns/1ps
module pmas_mgmt_master (
    input  wire logic clk_sys_i,
    input  wire logic line_i,
    output logic      mdc_o,
    output logic      drv_o,
    output logic      drv_oe_o
);
    initial begin
        mdc_o    = 1'b0;
        drv_o    = 1'b0;
        drv_oe_o = 1'b0;
    end

    // one mdc period of 320 ns, line sampled at the rise
    task automatic bit_cycle(input logic oe, input logic d, output logic s);
        mdc_o    <= 1'b0;
        drv_oe_o <= oe;
        drv_o    <= d;
        repeat (4) @(posedge clk_sys_i);
        s = line_i;
        mdc_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic frame(input int pre, input logic [1:0] op,
                         input logic [9:0] addr, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] hdr;
        logic        s;
        hdr = {2'b01, op, addr, (op == 2'b10) ? 2'b00 : 2'b10, wd};
        for (int i = 0; i < pre; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(i > 17 || op != 2'b10, hdr[i], s);
            if (i < 16) rd[i] = s;
        end
        bit_cycle(1'b0, 1'b0, s);
        mdc_o <= 1'b0;
        @(posedge clk_sys_i);
    endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pmas_pkg::*;
    logic         clk_sys_i;
    logic         reset_n_i;
    logic         mdio_o;
    logic         mdio_oe_o;
    logic         frame_busy_o;
    logic         mdc;
    logic         m_d;
    logic         m_oe;
    logic         saw_oe;
    logic         saw_clr;
    logic [1:0]   pins;
    logic [1:0]   b;
    logic [1:0]   base_o;
    pmas_an_evt_s evt [NUM_PORTS];
    int           n_fail;
    int           compares;
    int           seed;
    wire logic    mdio_line = mdio_oe_o ? mdio_o : (m_oe ? m_d : 1'b1);

    pmas_top u_pmas_top (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mdc_i(mdc),
        .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
        .port_address_base_pins_i(pins), .an_evt_i(evt),
        .port_address_base_o(base_o), .frame_busy_o(frame_busy_o));
    pmas_mgmt_master u_pmas_mgmt_master (.clk_sys_i(clk_sys_i),
        .line_i(mdio_line), .mdc_o(mdc), .drv_o(m_d), .drv_oe_o(m_oe));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (saw_clr) saw_oe <= 1'b0;
        else if (mdio_oe_o === 1'b1) saw_oe <= 1'b1;
    end

    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // order: restart, word_valid, pd_fault, page_rx, link_lost
    task automatic pulse(input int p, input logic [4:0] m);
        {evt[p].an_restart, evt[p].word_valid, evt[p].pd_fault,
         evt[p].page_rx, evt[p].link_lost} <= m;
        @(posedge clk_sys_i);
        {evt[p].an_restart, evt[p].word_valid, evt[p].pd_fault,
         evt[p].page_rx, evt[p].link_lost} <= 5'h00;
        @(posedge clk_sys_i);
    endtask
    function automatic logic [15:0] exp_exp(input logic np, pd, pg,
                                            en, fib, able);
        return {11'h000, pd, np, 1'b0, pg, (!en || fib) ? 1'b1 : able};
    endfunction
    task automatic rd(input int pre, input logic [9:0] a,
                      output logic [15:0] v);
        u_pmas_mgmt_master.frame(pre, OP_READ, a, 16'h0000, v);
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_fail++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        logic [15:0] w;
        logic [15:0] v;
        logic [4:0]  pa;
        reset_n_i = 1'b0;
        saw_clr = 1'b1;
        n_fail = 0;
        compares = 0;
        seed = 32'h7ee5;
        r = $random(seed);
        pins = r[1:0];
        b = r[1:0];
        for (int i = 0; i < NUM_PORTS; i++) evt[i] = '0;
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        saw_clr <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check("base", {14'h0000, b}, {14'h0000, base_o});
        pins <= ~b;
        repeat (4) @(posedge clk_sys_i);
        check("base held", {14'h0000, b}, {14'h0000, base_o});
        repeat (17500) @(posedge clk_sys_i);
        for (int i = 0; i < NUM_PORTS; i++) begin
            r = $random(seed);
            w = r[31:16];
            pa = {b, i[2:0]};
            {evt[i].an_enable, evt[i].fiber_100_mode,
             evt[i].partner_an_able} <= r[2:0];
            evt[i].word <= w;
            pulse(i, {1'b0, 1'b1, i[0], i[1], 1'b0});
            rd((i % 2 == 1) ? 0 : 32, {pa, REG_PARTNER_ABILITY}, v);
            check("partner", w & PARTNER_ABILITY_MASK, v);
            check("released", 16'h0000, {15'h0000, mdio_oe_o});
            rd(0, {pa, REG_AUTONEG_EXPANSION}, v);
            check("expansion", exp_exp(w[15], i[0], i[1], r[2], r[1], r[0]), v);
            rd(0, {pa, REG_AUTONEG_EXPANSION}, v);
            check("expansion", exp_exp(w[15], 1'b0, i[1], r[2], r[1], r[0]), v);
            pulse(i, 5'h11);
            rd(0, {pa, REG_PARTNER_ABILITY}, v);
            check("partner", 16'h0000, v);
            rd(0, {pa, REG_AUTONEG_EXPANSION}, v);
            check("expansion", exp_exp(1'b0, 1'b0, 1'b0, r[2], r[1], r[0]), v);
        end
        evt[0].word <= 16'hffff;
        pulse(0, 5'h08);
        saw_clr <= 1'b1;
        @(posedge clk_sys_i);
        saw_clr <= 1'b0;
        rd(0, {~b, 3'h0, REG_PARTNER_ABILITY}, v);
        check("other base", 16'hffff, v);
        check("other base oe", 16'h0000, {15'h0000, saw_oe});
        r = $random(seed);
        u_pmas_mgmt_master.frame(0, OP_WRITE, {b, 3'h0, REG_PARTNER_ABILITY},
                                 r[15:0], v);
        rd(0, {b, 3'h0, REG_PARTNER_ABILITY}, v);
        check("after write", 16'hffff & PARTNER_ABILITY_MASK, v);
        rd(0, {b, 3'h0, 5'h1f}, v);
        check("unmapped", READ_UNMAPPED, v);
        summarize();
    end
endmodule

bind pmas_top pmas_top_monitor u_pmas_top_monitor (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mdc_i(mdc_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
    .port_address_base_pins_i(port_address_base_pins_i),
    .port_address_base_o(port_address_base_o),
    .frame_busy_o(frame_busy_o));
